// File: bench/adt_dead_time_properties.sv
// Port checks of the dead time offset block.
// Assumes it is bound to the top module by name.
`timescale 1ns/1ps
`default_nettype none
module adt_dead_time_properties
  import adt_pkg::*;
#(
  parameter int EDGE_W = ADT_EDGE_W
)
(
  input wire logic                                 clk,
  input wire logic                                 sys_rst,
  input wire logic [ADT_ADDR_W-1:0]                reg_addr,
  input wire logic                                 reg_wr_en,
  input wire logic [ADT_DATA_W-1:0]                reg_wdata,
  input wire logic                                 reg_rd_en,
  input wire logic [ADT_DATA_W-1:0]                reg_rdata,
  input wire logic                                 reg_rd_valid,
  input wire logic                                 period_start,
  input wire logic                                 current_below_threshold,
  input wire logic [ADT_NUM_EDGES-1:0][EDGE_W-1:0] nominal_edge,
  input wire logic [ADT_NUM_EDGES-1:0][EDGE_W-1:0] adjusted_edge,
  input wire logic [ADT_THRESH_W-1:0]              dead_time_threshold,
  input wire logic                                 offsets_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_RD_VALID: assert property (reg_rd_en |=> reg_rd_valid)
    else $error("read answer missing");
  AST_RD_HOLD: assert property (!reg_rd_en |=> !reg_rd_valid && $stable(reg_rdata))
    else $error("read data moved");
  AST_WR_RD: assert property (reg_wr_en && reg_addr == ADT_ADDR_EDGES_ONE_TWO ##1
    reg_rd_en && !reg_wr_en && reg_addr == ADT_ADDR_EDGES_ONE_TWO
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("readback differs");
  AST_UNMAPPED: assert property (reg_rd_en && reg_addr > ADT_ADDR_EDGES_THREE_FOUR
    |=> reg_rdata == ADT_UNMAPPED_READ) else $error("unmapped read not zero");
  AST_THRESH: assert property (reg_wr_en && reg_addr == ADT_ADDR_THRESHOLD
    |=> ##1 dead_time_threshold == $past(reg_wdata[2:0], 2)) else $error("threshold copy");
  AST_GATE_RISE: assert property ($rose(offsets_active)
    |-> $past(period_start, 2) && $past(current_below_threshold, 2)) else $error("gate rise");
  AST_ACTIVE_HOLD: assert property ($changed(offsets_active)
    |-> $past(period_start, 2)) else $error("gate moved mid period");
  AST_EDGE_HOLD: assert property ($changed(adjusted_edge)
    |-> $past(period_start, 2) || $past(sys_rst, 2)
    || $past(nominal_edge) != $past(nominal_edge, 2)) else $error("edge moved mid period");
  AST_NOMINAL: assert property (!offsets_active && !$past(sys_rst)
    |-> adjusted_edge == $past(nominal_edge)) else $error("offset applied while off");
  cover property (reg_rd_en ##1 reg_rd_valid);
  cover property ($rose(offsets_active));
  cover property ($fell(offsets_active));
endmodule
`default_nettype wire

// File: bench/adt_pwm_partner.sv
// Switching period source standing in for the PWM timing side.
// Assumes one clock domain shared with the offset block.
`timescale 1ns/1ps
`default_nettype none
module adt_pwm_partner
#(
  parameter int PERIOD = 16
)
(
  input  wire logic clk,
  input  wire logic sys_rst,
  output var  logic period_start
);
  int count;
  always_ff @(posedge clk)
  begin
    count <= (sys_rst || count == PERIOD - 1) ? 0 : count + 1;
  end
  always_ff @(posedge clk)
  begin
    period_start <= !sys_rst && count == PERIOD - 1;
  end
endmodule
`default_nettype wire

// File: bench/tb_adt_dead_time.sv
// Self-checking bench of the dead time offset block.
// Assumes the period source model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_adt_dead_time;
  import adt_pkg::*;
  typedef struct packed {logic [7:0] r12; logic [7:0] r34; logic on; logic [47:0] adj;} adt_row_t;
  localparam logic [47:0] NOM = {12'h190, 12'h12c, 12'h0c8, 12'h064};
  logic                                  clk;
  logic                                  sys_rst;
  logic [7:0]                            reg_addr;
  logic                                  reg_wr_en;
  logic [7:0]                            reg_wdata;
  logic                                  reg_rd_en;
  logic [7:0]                            reg_rdata;
  logic                                  reg_rd_valid;
  logic                                  period_start;
  logic                                  below;
  logic [ADT_NUM_EDGES-1:0][ADT_EDGE_W-1:0] nominal_edge;
  logic [ADT_NUM_EDGES-1:0][ADT_EDGE_W-1:0] adjusted_edge;
  logic [2:0]                            thr;
  logic                                  active;
  int                                    fails = 0;
  int                                    comparisons = 0;
  adt_row_t rows [5] = '{
    '{8'h00, 8'h00, 1'b1, NOM},
    '{8'h7f, 8'h35, 1'b1, {12'h195, 12'h12f, 12'h0c1, 12'h06b}},
    '{8'h9a, 8'hf8, 1'b1, {12'h190, 12'h125, 12'h0c6, 12'h063}},
    '{8'h7f, 8'h35, 1'b0, NOM},
    '{8'h46, 8'hce, 1'b1, {12'h18a, 12'h128, 12'h0ce, 12'h068}}};
  adt_dead_time u_adt_dead_time (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .period_start(period_start), .current_below_threshold(below),
    .nominal_edge(nominal_edge), .adjusted_edge(adjusted_edge), .dead_time_threshold(thr),
    .offsets_active(active));
  adt_pwm_partner u_adt_pwm_partner (.clk(clk), .sys_rst(sys_rst), .period_start(period_start));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ----------------------------------------
  // Shared tasks.
  // ----------------------------------------
  task automatic close_out();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge clk);
    reg_wr_en = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge clk);
    reg_rd_en = 1'b0;
    chk(48'(reg_rd_valid), 48'h1);
    chk(48'(reg_rdata), 48'(e));
  endtask
  task automatic wait_period();
    int n;
    n = 0;
    while (period_start !== 1'b1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 40)
    begin
      fails++;
      close_out();
    end
    repeat (2) @(negedge clk);
  endtask
  // ----------------------------------------
  // Main sequence.
  // ----------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wdata = 8'h00;
    reg_rd_en = 1'b0;
    below = 1'b0;
    nominal_edge = NOM;
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    rd(ADT_ADDR_EDGES_ONE_TWO, ADT_RST_DEAD_TIME);
    @(negedge clk);
    rd(ADT_ADDR_EDGES_THREE_FOUR, ADT_RST_DEAD_TIME);
    chk(adjusted_edge, NOM);
    chk(48'(active), 48'h0);
    $display("reset test done");
    foreach (rows[i])
    begin
      wr(ADT_ADDR_EDGES_ONE_TWO, rows[i].r12);
      rd(ADT_ADDR_EDGES_ONE_TWO, rows[i].r12);
      wr(ADT_ADDR_EDGES_THREE_FOUR, rows[i].r34);
      rd(ADT_ADDR_EDGES_THREE_FOUR, rows[i].r34);
      below = rows[i].on;
      wait_period();
      chk(adjusted_edge, rows[i].adj);
      chk(48'(active), 48'(rows[i].on));
    end
    $display("table test done");
    wr(ADT_ADDR_EDGES_ONE_TWO, 8'h00);
    chk(adjusted_edge, rows[4].adj);
    wait_period();
    chk(adjusted_edge, {12'h18a, 12'h128, 12'h0c8, 12'h064});
    wr(8'h6b, 8'hff);
    rd(8'h6b, ADT_UNMAPPED_READ);
    nominal_edge = {12'h190, 12'h12c, 12'hffc, 12'h002};
    wr(ADT_ADDR_EDGES_ONE_TWO, 8'hf7);
    wait_period();
    chk(adjusted_edge, {12'h18a, 12'h128, 12'hfff, 12'h000});
    $display("saturation test done");
    wr(ADT_ADDR_THRESHOLD, 8'hfd);
    rd(ADT_ADDR_THRESHOLD, 8'hfd);
    chk(48'(thr), 48'h5);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    rd(ADT_ADDR_EDGES_THREE_FOUR, ADT_RST_DEAD_TIME);
    $display("awkward test done");
    close_out();
  end
endmodule
bind adt_dead_time adt_dead_time_properties #(.EDGE_W(EDGE_W)) u_adt_dead_time_properties (
  .clk, .sys_rst, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en, .reg_rdata, .reg_rd_valid,
  .period_start, .current_below_threshold, .nominal_edge, .adjusted_edge, .dead_time_threshold,
  .offsets_active);
`default_nettype wire

// File: verilog/adt_dead_time.sv
// Adaptive dead time offsets for the first four PWM edge timings.
// Assumes register port, period strobe and current flag are on clk.
//
// Function
// - A polarity bit of 0 moves its edge later and a bit of 1 moves it earlier.
// - The first dead time register holds edge one in bits 7 to 4 and edge two in bits 3 to 0.
// - The second dead time register holds edge three in bits 7 to 4 and edge four in bits 3 to 0.
// - Each offset code moves its edge by the code times 5 ns, up to 35 ns for code 7.
// - Edge three is shifted from its own nominal time on the same 5 ns scale as the rest.
// - Offsets apply only in periods that start with the secondary current below threshold, else nominal timing.
`timescale 1ns/1ps
`default_nettype none

module adt_dead_time
  import adt_pkg::*;
#(
  parameter int EDGE_W     = ADT_EDGE_W,
  parameter int STEP_TICKS = ADT_STEP_TICKS
)
(
  input  wire logic                                   clk,
  input  wire logic                                   sys_rst,
  input  wire logic [ADT_ADDR_W-1:0]                  reg_addr,
  input  wire logic                                   reg_wr_en,
  input  wire logic [ADT_DATA_W-1:0]                  reg_wdata,
  input  wire logic                                   reg_rd_en,
  output var  logic [ADT_DATA_W-1:0]                  reg_rdata,
  output var  logic                                   reg_rd_valid,
  input  wire logic                                   period_start,
  input  wire logic                                   current_below_threshold,
  input  wire logic [ADT_NUM_EDGES-1:0][EDGE_W-1:0]   nominal_edge,
  output var  logic [ADT_NUM_EDGES-1:0][EDGE_W-1:0]   adjusted_edge,
  output var  logic [ADT_THRESH_W-1:0]                dead_time_threshold,
  output var  logic                                   offsets_active
);

  import adt_pkg::*;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------

  logic [ADT_DATA_W-1:0] threshold_setting;
  logic [ADT_DATA_W-1:0] dead_time_edges_one_two;
  logic [ADT_DATA_W-1:0] dead_time_edges_three_four;
  logic [ADT_DATA_W-1:0] active_one_two;
  logic [ADT_DATA_W-1:0] active_three_four;
  logic                  apply_offsets;
  logic [ADT_DATA_W-1:0] next_rdata;

  logic                  wr_threshold;
  logic                  wr_one_two;
  logic                  wr_three_four;

  assign wr_threshold  = reg_wr_en && (reg_addr == ADT_ADDR_THRESHOLD);
  assign wr_one_two    = reg_wr_en && (reg_addr == ADT_ADDR_EDGES_ONE_TWO);
  assign wr_three_four = reg_wr_en && (reg_addr == ADT_ADDR_EDGES_THREE_FOUR);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      threshold_setting <= ADT_RST_THRESHOLD;
    end
    else if (wr_threshold)
    begin
      threshold_setting <= reg_wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dead_time_edges_one_two <= ADT_RST_DEAD_TIME;
    end
    else if (wr_one_two)
    begin
      dead_time_edges_one_two <= reg_wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dead_time_edges_three_four <= ADT_RST_DEAD_TIME;
    end
    else if (wr_three_four)
    begin
      dead_time_edges_three_four <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------

  always_comb
  begin
    unique case (reg_addr)
      ADT_ADDR_THRESHOLD:        next_rdata = threshold_setting;
      ADT_ADDR_EDGES_ONE_TWO:    next_rdata = dead_time_edges_one_two;
      ADT_ADDR_EDGES_THREE_FOUR: next_rdata = dead_time_edges_three_four;
      default:                   next_rdata = ADT_UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      reg_rdata <= ADT_UNMAPPED_READ;
    end
    else if (reg_rd_en)
    begin
      reg_rdata <= next_rdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      reg_rd_valid <= 1'b0;
    end
    else
    begin
      reg_rd_valid <= reg_rd_en;
    end
  end

  // ----------------------------------------------------------------
  // Period-aligned settings and the threshold output copy
  // ----------------------------------------------------------------

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      active_one_two    <= ADT_RST_DEAD_TIME;
      active_three_four <= ADT_RST_DEAD_TIME;
    end
    else if (period_start)
    begin
      active_one_two    <= dead_time_edges_one_two;
      active_three_four <= dead_time_edges_three_four;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      apply_offsets <= 1'b0;
    end
    else if (period_start)
    begin
      apply_offsets <= current_below_threshold;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      offsets_active <= 1'b0;
    end
    else
    begin
      offsets_active <= apply_offsets;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dead_time_threshold <= ADT_RST_THRESHOLD[ADT_THRESH_MSB:0];
    end
    else
    begin
      dead_time_threshold <= threshold_setting[ADT_THRESH_MSB:0];
    end
  end

  // ----------------------------------------------------------------
  // Per-edge offset decode and shift
  // ----------------------------------------------------------------

  genvar gi;
  generate
    for (gi = 0; gi < ADT_NUM_EDGES; gi++)
    begin : g_edge
      logic [ADT_DATA_W-1:0] src;

      adt_edge_if #(.EDGE_W(EDGE_W)) edge_bus ();

      assign src = (gi < 2) ? active_one_two : active_three_four;

      if ((gi % 2) == 0)
      begin : g_hi
        assign edge_bus.polarity = src[ADT_POL_HI_BIT];
        assign edge_bus.offset   = src[ADT_OFS_HI_MSB:ADT_OFS_HI_LSB];
      end
      else
      begin : g_lo
        assign edge_bus.polarity = src[ADT_POL_LO_BIT];
        assign edge_bus.offset   = src[ADT_OFS_LO_MSB:ADT_OFS_LO_LSB];
      end

      assign edge_bus.nominal = nominal_edge[gi];
      assign edge_bus.apply   = apply_offsets;

      adt_edge_offset #(
        .EDGE_W     (EDGE_W),
        .STEP_TICKS (STEP_TICKS)
      ) u_offset (
        .lane (edge_bus.calc)
      );

      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          adjusted_edge[gi] <= '0;
        end
        else
        begin
          adjusted_edge[gi] <= edge_bus.adjusted;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// File: verilog/adt_edge_if.sv
// Interface carrying one edge's nominal time, offset setting and adjusted time.
// Assumes the controller drives the settings and the calculator returns the result.
`timescale 1ns/1ps
`default_nettype none

interface adt_edge_if
  import adt_pkg::*;
#(
  parameter int EDGE_W = ADT_EDGE_W
);
  logic [EDGE_W-1:0] nominal;
  logic              polarity;
  adt_offset_t       offset;
  logic              apply;
  logic [EDGE_W-1:0] adjusted;

  modport ctrl
  (
    output nominal,
    output polarity,
    output offset,
    output apply,
    input  adjusted
  );

  modport calc
  (
    input  nominal,
    input  polarity,
    input  offset,
    input  apply,
    output adjusted
  );
endinterface

`default_nettype wire

// File: verilog/adt_edge_offset.sv
// Combinational shift of one PWM edge by its signed-magnitude offset.
// Assumes nominal time in timing ticks; result saturates at the range ends.
`timescale 1ns/1ps
`default_nettype none

module adt_edge_offset
  import adt_pkg::*;
#(
  parameter int EDGE_W     = ADT_EDGE_W,
  parameter int STEP_TICKS = ADT_STEP_TICKS
)
(
  adt_edge_if.calc lane
);

  logic [EDGE_W:0] nom_ext;
  logic [EDGE_W:0] shift_ext;
  logic [EDGE_W:0] sum_ext;

  assign nom_ext = {1'b0, lane.nominal};
  assign shift_ext = (EDGE_W+1)'((EDGE_W+1)'(lane.offset) * (EDGE_W+1)'(STEP_TICKS));
  assign sum_ext = nom_ext + shift_ext;

  always_comb
  begin
    if (!lane.apply)
    begin
      lane.adjusted = lane.nominal;
    end
    else if (!lane.polarity)
    begin
      lane.adjusted = sum_ext[EDGE_W] ? {EDGE_W{1'b1}} : sum_ext[EDGE_W-1:0];
    end
    else if (shift_ext > nom_ext)
    begin
      lane.adjusted = '0;
    end
    else
    begin
      lane.adjusted = lane.nominal - shift_ext[EDGE_W-1:0];
    end
  end

endmodule

`default_nettype wire

// File: verilog/adt_pkg.sv
// Constants, offsets and field layout for the adaptive dead time offset block.
// Assumes nominal edge timings arrive in ticks of the PWM timing resolution.
`default_nettype none

package adt_pkg;

  localparam int ADT_NUM_EDGES = 4;
  localparam int ADT_ADDR_W = 8;
  localparam int ADT_DATA_W = 8;
  localparam int ADT_OFFSET_W = 3;
  localparam int ADT_THRESH_W = 3;
  localparam int ADT_EDGE_W = 12;

  localparam logic [ADT_ADDR_W-1:0] ADT_ADDR_THRESHOLD = 8'h68;
  localparam logic [ADT_ADDR_W-1:0] ADT_ADDR_EDGES_ONE_TWO = 8'h69;
  localparam logic [ADT_ADDR_W-1:0] ADT_ADDR_EDGES_THREE_FOUR = 8'h6a;

  localparam int ADT_POL_HI_BIT = 7;
  localparam int ADT_OFS_HI_MSB = 6;
  localparam int ADT_OFS_HI_LSB = 4;
  localparam int ADT_POL_LO_BIT = 3;
  localparam int ADT_OFS_LO_MSB = 2;
  localparam int ADT_OFS_LO_LSB = 0;
  localparam int ADT_THRESH_MSB = 2;

  localparam logic [ADT_DATA_W-1:0] ADT_RST_THRESHOLD = 8'h00;
  localparam logic [ADT_DATA_W-1:0] ADT_RST_DEAD_TIME = 8'h00;
  localparam logic [ADT_DATA_W-1:0] ADT_UNMAPPED_READ = 8'h00;

  localparam int ADT_CLK_PERIOD_NS = 20;
  localparam int ADT_OFFSET_STEP_NS = 5;
  localparam int ADT_OFFSET_MAX_NS = 35;
  localparam int ADT_TICK_NS = 5;
  localparam int ADT_STEP_TICKS = ADT_OFFSET_STEP_NS / ADT_TICK_NS;

  typedef logic [ADT_OFFSET_W-1:0] adt_offset_t;

endpackage

`default_nettype wire
